// ===== src/sfe_config_bank.sv
// Function
// - Four order bits, one per pulse, repeating
// - Zero normal, one reversed; reset zero
// - Window width bits 15:11, 1 us units
// - Window offset bits 10:0, 31.25 ns units
// - Bit 9 picks buffer gain 1 or 0.7
// - Bit 7 makes integrator a buffer
// - Bit 6 enables per-channel gain sources
// - Channels 2-4 gains at bits 5:0
// - Gain codes 200k,100k,50k,25k; reset zero
// - Second slot ch2 gain bits 7:6
// - Reference select bits 5:4, reset 3
// - Disabled individual gain: one field for all
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module sfe_config_bank
  import sfe_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [SFE_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [SFE_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  pulse_strobe,
  input  wire logic                  sequence_restart,
  output logic                       integration_reversed,
  output logic [1:0]                 pulse_index,
  output logic [3:0]                 pulse_polarity_order,
  output logic [4:0]                 window_width,
  output logic [8:0]                 window_width_cycles,
  output logic [10:0]                window_offset,
  output logic [5:0]                 front_end_mode_field,
  output logic                       buffer_gain_select,
  output logic                       integrator_bypass,
  output logic                       per_channel_gain_enable,
  output logic [1:0]                 reference_level_select,
  output logic [7:0]                 first_slot_gain,
  output logic [1:0]                 second_slot_ch2_gain,
  output logic                       second_slot_ch2_gain_apply
);

  logic                 wr_fire;
  logic [SFE_IDX_W-1:0] wr_idx;
  logic [15:0]          wr_data;
  logic [1:0]           wr_strb;
  logic                 wr_hit;
  logic [SFE_IDX_W-1:0] rd_idx;
  logic [15:0]          rd_data;
  logic                 rd_hit;
  logic [15:0]          reg_order;
  logic [15:0]          reg_timing;
  logic [15:0]          reg_cfg_a;
  logic [15:0]          reg_cfg_b;
  logic [15:0]          reg_gain;
  logic [7:0]           next_channel_gain;

  // ==========================================================================
  // Bus slave
  sfe_axil_slave u_bus (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .wr_fire (wr_fire),
    .wr_idx  (wr_idx),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_hit  (wr_hit),
    .rd_idx  (rd_idx),
    .rd_data (rd_data),
    .rd_hit  (rd_hit)
  );

  assign wr_hit = sfe_idx_hit(wr_idx);
  assign rd_hit = sfe_idx_hit(rd_idx);

  // ==========================================================================
  // Register storage; reserved bits are kept so writes read back as given
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      reg_order <= SFE_RST_ORDER;
    else if (wr_fire && wr_idx == SFE_IDX_ORDER)
      reg_order <= sfe_merge(reg_order, wr_data, wr_strb);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      reg_timing <= SFE_RST_TIMING;
    else if (wr_fire && wr_idx == SFE_IDX_TIMING)
      reg_timing <= sfe_merge(reg_timing, wr_data, wr_strb);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      reg_cfg_a <= SFE_RST_CFG_A;
    else if (wr_fire && wr_idx == SFE_IDX_CFG_A)
      reg_cfg_a <= sfe_merge(reg_cfg_a, wr_data, wr_strb);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      reg_cfg_b <= SFE_RST_CFG_B;
    else if (wr_fire && wr_idx == SFE_IDX_CFG_B)
      reg_cfg_b <= sfe_merge(reg_cfg_b, wr_data, wr_strb);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      reg_gain <= SFE_RST_GAIN;
    else if (wr_fire && wr_idx == SFE_IDX_GAIN)
      reg_gain <= sfe_merge(reg_gain, wr_data, wr_strb);
  end

  // ==========================================================================
  // Read mux; unmapped words read zero with an error response
  always_comb
  begin
    if (rd_idx == SFE_IDX_ORDER)
      rd_data = reg_order;
    else if (rd_idx == SFE_IDX_TIMING)
      rd_data = reg_timing;
    else if (rd_idx == SFE_IDX_CFG_A)
      rd_data = reg_cfg_a;
    else if (rd_idx == SFE_IDX_CFG_B)
      rd_data = reg_cfg_b;
    else if (rd_idx == SFE_IDX_GAIN)
      rd_data = reg_gain;
    else
      rd_data = 16'h0000;
  end

  // ==========================================================================
  // Field outputs taken straight from the storage flops
  assign pulse_polarity_order    = reg_order[3:0];
  assign window_width            = reg_timing[SFE_WIDTH_MSB:SFE_WIDTH_LSB];
  assign window_offset           = reg_timing[SFE_OFFSET_MSB:0];
  assign front_end_mode_field    = reg_cfg_a[15:SFE_MODE_LSB];
  assign buffer_gain_select      = reg_cfg_a[SFE_BUF_GAIN_BIT];
  assign integrator_bypass       = reg_cfg_a[SFE_INT_BUF_BIT];
  assign per_channel_gain_enable = reg_cfg_a[SFE_IND_EN_BIT];
  assign reference_level_select  = reg_cfg_a[SFE_VREF_LSB+1:SFE_VREF_LSB];

  // Window width in clock cycles, for logic timing the window locally
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      window_width_cycles <= 9'(SFE_RST_WIDTH) * SFE_WIDTH_CYC;
    else
      window_width_cycles <= 9'(window_width) * SFE_WIDTH_CYC;
  end

  // ==========================================================================
  // Pulse polarity sequencing; index wraps after the fourth pulse
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pulse_index          <= 2'h0;
      integration_reversed <= 1'b0;
    end
    else if (sequence_restart)
    begin
      pulse_index          <= 2'h0;
      integration_reversed <= 1'b0;
    end
    else if (pulse_strobe)
    begin
      integration_reversed <= reg_order[pulse_index];
      pulse_index          <= pulse_index + 2'h1;
    end
  end

  // ==========================================================================
  // Gain routing; outputs lag a register write by one cycle
  sfe_gain_route u_route (
    .ind_en            (reg_cfg_a[SFE_IND_EN_BIT]),
    .slot_gain_field   (reg_cfg_a[1:0]),
    .ch_gain_word      (reg_gain[5:0]),
    .next_channel_gain (next_channel_gain)
  );

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      first_slot_gain <= 8'h00;
    else
      first_slot_gain <= next_channel_gain;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      second_slot_ch2_gain       <= 2'h0;
      second_slot_ch2_gain_apply <= 1'b0;
    end
    else
    begin
      second_slot_ch2_gain       <= reg_gain[SFE_B2_GAIN_LSB+1:SFE_B2_GAIN_LSB];
      second_slot_ch2_gain_apply <= reg_cfg_b[SFE_IND_EN_BIT];
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_reset_defaults: assert property (disable iff (1'b0) !aresetn |=>
    reg_timing == SFE_RST_TIMING && reg_cfg_a == SFE_RST_CFG_A && reg_gain == SFE_RST_GAIN
    && reg_order == SFE_RST_ORDER)
    else $error("registers not at defaults after reset");
  a_vref_default: assert property (disable iff (1'b0) !aresetn |=>
    reference_level_select == SFE_RST_VREF && window_offset == SFE_RST_OFFSET)
    else $error("reference select or offset default wrong");
  a_order_pulse: assert property (pulse_strobe && !sequence_restart |=>
    integration_reversed == $past(reg_order[pulse_index]))
    else $error("pulse polarity not taken from order bit");
  a_order_wrap: assert property
    (pulse_strobe && !sequence_restart && pulse_index == 2'h3 |=> pulse_index == 2'h0)
    else $error("pulse index did not wrap after four");
  a_width_write: assert property
    (wr_fire && wr_idx == SFE_IDX_TIMING && wr_strb[1] |=>
     window_width == $past(wr_data[15:11]) ##1 window_width_cycles == 9'(window_width) * 9'h00a)
    else $error("window width not written");
  a_offset_write: assert property
    (wr_fire && wr_idx == SFE_IDX_TIMING && wr_strb == 2'h3 |=>
     window_offset == $past(wr_data[10:0]))
    else $error("window offset not written");
  a_mode_bits: assert property
    (wr_fire && wr_idx == SFE_IDX_CFG_A && wr_strb[1] && wr_strb[0] |=>
     buffer_gain_select == $past(wr_data[9]) && integrator_bypass == $past(wr_data[7]))
    else $error("buffer gain or bypass bit not written");
  a_ind_gain: assert property
    (reg_cfg_a[6] |=> first_slot_gain == {$past(reg_gain[5:0]), $past(reg_cfg_a[1:0])})
    else $error("individual gains not routed");
  a_common_gain: assert property
    (!reg_cfg_a[6] |=> first_slot_gain == {4{$past(reg_cfg_a[1:0])}})
    else $error("common slot gain not applied to all channels");
  a_slot_b_gain: assert property
    (1'b1 |=> second_slot_ch2_gain == $past(reg_gain[7:6])
              && second_slot_ch2_gain_apply == $past(reg_cfg_b[6]))
    else $error("second slot channel two gain wrong");
  a_readback: assert property
    ($rose(s_axi_rvalid) && rd_idx == SFE_IDX_GAIN |->
     s_axi_rdata == {16'h0000, reg_gain} && s_axi_rresp == SFE_RESP_OKAY)
    else $error("gain register read back wrong");
  a_write_resp: assert property
    (wr_fire |=> s_axi_bvalid && s_axi_bresp == ($past(wr_hit) ? SFE_RESP_OKAY : SFE_RESP_SLVERR))
    else $error("write response missing or wrong");
  a_order_write: assert property
    (wr_fire && wr_idx == SFE_IDX_ORDER && wr_strb[0] |=> pulse_polarity_order == $past(wr_data[3:0]))
    else $error("pulse order bits not written");
  a_vref_write: assert property
    (wr_fire && wr_idx == SFE_IDX_CFG_A && wr_strb[0] |=> reference_level_select == $past(wr_data[5:4]))
    else $error("reference select not written");
  a_restart_clear: assert property
    (sequence_restart |=> pulse_index == 2'h0 && !integration_reversed)
    else $error("restart did not clear pulse sequence");
  a_unmapped_hold: assert property
    (wr_fire && !wr_hit |=> $stable(reg_order) && $stable(reg_timing) && $stable(reg_cfg_a)
     && $stable(reg_cfg_b) && $stable(reg_gain))
    else $error("unmapped write changed a register");

  c_ind_enabled: cover property (wr_fire && wr_idx == SFE_IDX_CFG_A && wr_data[6]);
  c_order_wrap:  cover property (pulse_strobe && pulse_index == 2'h3);
  c_bad_read:    cover property (s_axi_rvalid && s_axi_rresp == SFE_RESP_SLVERR);
  c_readback:    cover property (s_axi_rvalid && s_axi_rready && rd_idx == SFE_IDX_TIMING);
  c_slot_b_on:   cover property (second_slot_ch2_gain_apply && second_slot_ch2_gain == 2'h3);

endmodule : sfe_config_bank
`default_nettype wire

// ===== src/sfe_pkg.sv
package sfe_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int          SFE_ADDR_W       = 12;
  localparam int          SFE_IDX_W        = SFE_ADDR_W - 2;
  localparam logic [1:0]  SFE_RESP_OKAY    = 2'h0;
  localparam logic [1:0]  SFE_RESP_SLVERR  = 2'h2;

  // ==========================================================================
  // Register indices; byte address is four times the index
  localparam logic [9:0]  SFE_IDX_ORDER    = 10'h017;
  localparam logic [9:0]  SFE_IDX_TIMING   = 10'h039;
  localparam logic [9:0]  SFE_IDX_CFG_A    = 10'h042;
  localparam logic [9:0]  SFE_IDX_CFG_B    = 10'h044;
  localparam logic [9:0]  SFE_IDX_GAIN     = 10'h055;

  // ==========================================================================
  // Values after reset
  localparam logic [15:0] SFE_RST_ORDER    = 16'h0000;
  localparam logic [15:0] SFE_RST_TIMING   = 16'h22fc;
  localparam logic [15:0] SFE_RST_CFG_A    = 16'h1c38;
  localparam logic [15:0] SFE_RST_CFG_B    = 16'h1c00;
  localparam logic [15:0] SFE_RST_GAIN     = 16'h0000;
  localparam logic [3:0]  SFE_RST_ORDER_F  = 4'h0;
  localparam logic [4:0]  SFE_RST_WIDTH    = 5'h04;
  localparam logic [10:0] SFE_RST_OFFSET   = 11'h2fc;
  localparam logic [1:0]  SFE_RST_VREF     = 2'h3;

  // ==========================================================================
  // Field positions
  localparam int          SFE_WIDTH_MSB    = 15;
  localparam int          SFE_WIDTH_LSB    = 11;
  localparam int          SFE_OFFSET_MSB   = 10;
  localparam int          SFE_MODE_LSB     = 10;
  localparam int          SFE_BUF_GAIN_BIT = 9;
  localparam int          SFE_INT_BUF_BIT  = 7;
  localparam int          SFE_IND_EN_BIT   = 6;
  localparam int          SFE_VREF_LSB     = 4;
  localparam int          SFE_B2_GAIN_LSB  = 6;

  // ==========================================================================
  // Timing
  localparam int          SFE_CLK_PERIOD_NS = 100;
  localparam int          SFE_WIDTH_UNIT_NS = 1000;
  localparam logic [8:0]  SFE_WIDTH_CYC     = 9'(SFE_WIDTH_UNIT_NS / SFE_CLK_PERIOD_NS);

  function automatic logic sfe_idx_hit(input logic [SFE_IDX_W-1:0] idx);
    return (idx == SFE_IDX_ORDER) || (idx == SFE_IDX_TIMING) || (idx == SFE_IDX_CFG_A)
        || (idx == SFE_IDX_CFG_B) || (idx == SFE_IDX_GAIN);
  endfunction : sfe_idx_hit

  function automatic logic [15:0] sfe_merge(input logic [15:0] old_val,
                                            input logic [15:0] new_val,
                                            input logic [1:0]  strb);
    return {strb[1] ? new_val[15:8] : old_val[15:8], strb[0] ? new_val[7:0] : old_val[7:0]};
  endfunction : sfe_merge

endpackage : sfe_pkg

// ===== src/sfe_axil_slave.sv
`timescale 1ns/1ns
`default_nettype none
module sfe_axil_slave
  import sfe_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [SFE_ADDR_W-1:0] awaddr,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  input  wire logic [SFE_ADDR_W-1:0] araddr,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready,
  output logic                       wr_fire,
  output logic [SFE_IDX_W-1:0]       wr_idx,
  output logic [15:0]                wr_data,
  output logic [1:0]                 wr_strb,
  input  wire logic                  wr_hit,
  output logic [SFE_IDX_W-1:0]       rd_idx,
  input  wire logic [15:0]           rd_data,
  input  wire logic                  rd_hit
);

  logic rd_pend;

  // ==========================================================================
  // Write path: address and data taken in either order
  assign wr_fire = !awready && !wready && !bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= SFE_RESP_OKAY;
      wr_idx  <= '0;
      wr_data <= 16'h0000;
      wr_strb <= 2'h0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awready <= 1'b0;
        wr_idx  <= awaddr[SFE_ADDR_W-1:2];
      end
      if (wvalid && wready)
      begin
        wready  <= 1'b0;
        wr_data <= wdata[15:0];
        wr_strb <= wstrb[1:0];
      end
      if (wr_fire)
      begin
        bvalid <= 1'b1;
        bresp  <= wr_hit ? SFE_RESP_OKAY : SFE_RESP_SLVERR;
      end
      if (bvalid && bready)
      begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Read path
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rd_pend <= 1'b0;
      rd_idx  <= '0;
      rdata   <= 32'h00000000;
      rresp   <= SFE_RESP_OKAY;
    end
    else
    begin
      if (arvalid && arready)
      begin
        arready <= 1'b0;
        rd_idx  <= araddr[SFE_ADDR_W-1:2];
        rd_pend <= 1'b1;
      end
      if (rd_pend)
      begin
        rd_pend <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= {16'h0000, rd_data};
        rresp   <= rd_hit ? SFE_RESP_OKAY : SFE_RESP_SLVERR;
      end
      if (rvalid && rready)
      begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

endmodule : sfe_axil_slave
`default_nettype wire

// ===== src/sfe_gain_route.sv
`timescale 1ns/1ns
`default_nettype none
module sfe_gain_route
(
  input  wire logic       ind_en,
  input  wire logic [1:0] slot_gain_field,
  input  wire logic [5:0] ch_gain_word,
  output logic      [7:0] next_channel_gain
);

  // ==========================================================================
  // Channel 1 in bits 1:0, channel 4 in bits 7:6; codes pass unchanged
  always_comb
  begin
    if (ind_en)
      next_channel_gain = {ch_gain_word, slot_gain_field};
    else
      next_channel_gain = {4{slot_gain_field}};
  end

endmodule : sfe_gain_route
`default_nettype wire

// ===== test/slot_a_front_end_config_bank_test.sv
`timescale 1ns/1ns
`default_nettype none
module slot_a_front_end_config_bank_test
  import sfe_pkg::*;
;
  // ==========================================================================
  // Signals
  logic                  aclk;
  logic                  aresetn;
  logic [SFE_ADDR_W-1:0] awaddr;
  logic                  awvalid;
  logic                  awready;
  logic [31:0]           wdata;
  logic [3:0]            wstrb;
  logic                  wvalid;
  logic                  wready;
  logic [1:0]            bresp;
  logic                  bvalid;
  logic                  bready;
  logic [SFE_ADDR_W-1:0] araddr;
  logic                  arvalid;
  logic                  arready;
  logic [31:0]           rdata;
  logic [1:0]            rresp;
  logic                  rvalid;
  logic                  rready;
  logic                  pulse_strobe;
  logic                  sequence_restart;
  logic                  rev;
  logic [1:0]            pidx;
  logic [3:0]            order;
  logic [4:0]            width;
  logic [8:0]            wcyc;
  logic [10:0]           offs;
  logic [5:0]            mode;
  logic                  bgain;
  logic                  bypass;
  logic                  ind_en;
  logic [1:0]            vref;
  logic [7:0]            gain_a;
  logic [1:0]            b2_gain;
  logic                  b2_apply;
  logic [31:0]           rd_val;
  logic [1:0]            rsp;
  int                    fail_count;
  int                    checked;

  sfe_config_bank dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pulse_strobe(pulse_strobe),
    .sequence_restart(sequence_restart), .integration_reversed(rev), .pulse_index(pidx),
    .pulse_polarity_order(order), .window_width(width), .window_width_cycles(wcyc),
    .window_offset(offs), .front_end_mode_field(mode), .buffer_gain_select(bgain),
    .integrator_bypass(bypass), .per_channel_gain_enable(ind_en),
    .reference_level_select(vref), .first_slot_gain(gain_a),
    .second_slot_ch2_gain(b2_gain), .second_slot_ch2_gain_apply(b2_apply));

  // ==========================================================================
  // Tasks
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Master holds each channel until its own handshake edge
  task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {16'h0000, d};
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready)
      begin
        rsp = bresp;
        bready <= 1'b0;
        break;
      end
      n++;
      if (n > 50)
      begin
        chk("write_done", 32'h1, 32'h0);
        break;
      end
    end
  endtask : wr

  task automatic rd(input logic [11:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready)
      begin
        rd_val = rdata;
        rsp = rresp;
        rready <= 1'b0;
        break;
      end
      n++;
      if (n > 50)
      begin
        chk("read_done", 32'h1, 32'h0);
        break;
      end
    end
  endtask : rd

  task automatic rchk(input logic [9:0] idx, input logic [15:0] e, input string nm);
    rd({idx, 2'b00});
    chk(nm, {16'h0000, e}, rd_val);
    chk("rresp", 32'(SFE_RESP_OKAY), 32'(rsp));
  endtask : rchk

  // Outputs trail the register by one cycle, so let two edges pass
  task automatic wchk(input logic [9:0] idx, input logic [15:0] d);
    wr({idx, 2'b00}, d, 4'hf);
    chk("bresp", 32'(SFE_RESP_OKAY), 32'(rsp));
    repeat (2) @(posedge aclk);
    #1;
  endtask : wchk

  task automatic pulse(input bit restart);
    @(posedge aclk);
    if (restart) sequence_restart <= 1'b1;
    else pulse_strobe <= 1'b1;
    @(posedge aclk);
    sequence_restart <= 1'b0;
    pulse_strobe <= 1'b0;
    #1;
  endtask : pulse

  // ==========================================================================
  // Clock, watchdog, tests
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  initial
  begin
    #(100 * 20000);
    fail_count++;
    tally_and_finish();
  end

  initial
  begin
    logic [3:0] pat;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {pulse_strobe, sequence_restart} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    fail_count = 0;
    checked = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(SFE_IDX_ORDER, 16'h0000, "order");
    rchk(SFE_IDX_TIMING, 16'h22fc, "timing");
    rchk(SFE_IDX_CFG_A, 16'h1c38, "cfg_a");
    rchk(SFE_IDX_GAIN, 16'h0000, "gain");
    chk("width", 32'h4, 32'(width));
    chk("offset", 32'h2fc, 32'(offs));
    chk("vref", 32'h3, 32'(vref));
    chk("bgain", 32'h0, {bgain, bypass, gain_a});
    chk("b2_reset", 32'h0, {b2_gain, b2_apply});
    rd(12'h000);
    chk("rresp_unmapped", 32'(SFE_RESP_SLVERR), 32'(rsp));
    chk("rdata_unmapped", 32'h0, rd_val);
    wr(12'h000, 16'hffff, 4'hf);
    chk("bresp_unmapped", 32'(SFE_RESP_SLVERR), 32'(rsp));
    wchk(SFE_IDX_TIMING, 16'hffff);
    chk("width_max", {5'h1f, 11'h7ff, 9'h136}, {width, offs, wcyc});
    wchk(SFE_IDX_TIMING, 16'h0801);
    chk("width_min", {5'h01, 11'h001, 9'h00a}, {width, offs, wcyc});
    rchk(SFE_IDX_TIMING, 16'h0801, "timing_back");
    // Shared field drives all four channels while individual gain is off
    for (int v = 0; v < 4; v++)
    begin
      wchk(SFE_IDX_CFG_A, {6'h07, 4'b1010, 2'(v), 4'b0110});
      chk("vref_code", 32'(v), 32'(vref));
      chk("mode_bits", 32'h3e, {mode, bgain, bypass, ind_en});
      chk("gain_all", 32'haa, 32'(gain_a));
      rchk(SFE_IDX_CFG_A, {6'h07, 4'b1010, 2'(v), 4'b0110}, "cfg_a_back");
    end
    wchk(SFE_IDX_CFG_A, {6'h07, 4'b0001, 2'h3, 4'b0110});
    chk("ind_bits", 32'h1, {bgain, bypass, ind_en});
    wchk(SFE_IDX_GAIN, 16'h00e4);
    chk("gain_ind", 32'h92, 32'(gain_a));
    wchk(SFE_IDX_CFG_B, 16'h1c40);
    chk("b2_gain", 32'h7, {b2_gain, b2_apply});
    wr({SFE_IDX_GAIN, 2'b00}, 16'hff1b, 4'h1);
    repeat (2) @(posedge aclk);
    #1;
    chk("gain_strobe", 32'h6e, 32'(gain_a));
    rchk(SFE_IDX_GAIN, 16'h001b, "gain_back");
    wchk(SFE_IDX_CFG_A, {6'h07, 4'b0000, 2'h3, 4'b0110});
    chk("gain_off", 32'haa, 32'(gain_a));
    pat = 4'b1010;
    wchk(SFE_IDX_ORDER, {12'h000, pat});
    chk("order_out", 32'(pat), 32'(order));
    pulse(1'b1);
    for (int i = 0; i < 6; i++)
    begin
      pulse(1'b0);
      chk("reversed", 32'(pat[i % 4]), 32'(rev));
      chk("pulse_index", 32'((i + 1) % 4), 32'(pidx));
    end
    pulse(1'b1);
    chk("restart", 32'h0, {rev, pidx});
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(SFE_IDX_TIMING, 16'h22fc, "timing_rst");
    rchk(SFE_IDX_ORDER, 16'h0000, "order_rst");
    rchk(SFE_IDX_GAIN, 16'h0000, "gain_rst");
    tally_and_finish();
  end
endmodule : slot_a_front_end_config_bank_test
`default_nettype wire
